// file: include/pwm_scaler_map.vh
/*
 register offsets, field positions, reset values and timing counts
 for the pwm sample and interrupt scaler; included by bare name.
*/
`ifndef PWM_SCALER_MAP_VH
`define PWM_SCALER_MAP_VH

// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_PERIOD    8'h04
`define OFF_SAMPLE    8'h08
`define OFF_STATUS    8'h0c
`define OFF_CLEAR     8'h10
`define OFF_ENABLE    8'h14
`define OFF_COUNT     8'h18

// control field positions
`define CTRL_RUN      0
`define CTRL_OVS_LO   4
`define CTRL_OVS_HI   5
`define CTRL_DIV_LO   8
`define CTRL_DIV_HI   11

// status bits
`define ST_SAMPLE     0
`define ST_PERIOD     1
`define ST_SCALED     2

// reset values
`define RST_CTRL      32'h0000_0100
`define RST_PERIOD    14'h03e8
`define RST_SAMPLE    12'h000

// bus answers
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

// counter widths and clock ratio
`define CNT_W         14
`define SLOW_SHIFT    2

`endif

// file: verilog/period_timebase.v
/*
 14-bit pwm period counter with end-of-period pulse.
 assumes period register holds the count of fast clocks minus one.
*/
`timescale 1ns/10ps
module period_timebase (
  sys_clk,
  rst_n,
  run,
  period,
  count,
  wrap
);
`include "pwm_scaler_map.vh"
  input  wire                sys_clk;
  input  wire                rst_n;
  input  wire                run;
  input  wire [`CNT_W-1:0]   period;
  output reg  [`CNT_W-1:0]   count;
  output wire                wrap;

  // wrap at the programmed period
  assign wrap = run & (count >= period);

  ////////////////////////////////////////////////////////////////////
  // free running time base while enabled
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {`CNT_W{1'b0}};
    end else if (!run || wrap) begin
      count <= {`CNT_W{1'b0}};
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // period_timebase

// file: verilog/div_lookup.v
/*
 maps interrupt divide setting to its divide count.
 assumes setting zero behaves like setting one.
*/
`timescale 1ns/10ps
module div_lookup (
  setting,
  count
);
  input  wire [3:0] setting;
  output reg  [7:0] count;

  // fixed divide table
  always @* begin
    case (setting)
      4'h2:    count = 8'h01;
      4'h3:    count = 8'h03;
      4'h4:    count = 8'h07;
      4'h5:    count = 8'h0f;
      4'h6:    count = 8'h1f;
      4'h7:    count = 8'h2f;
      4'h8:    count = 8'h3f;
      4'h9:    count = 8'h4f;
      4'ha:    count = 8'h5f;
      4'hb:    count = 8'h7f;
      4'hc:    count = 8'h9f;
      4'hd:    count = 8'hbf;
      4'he:    count = 8'hdf;
      4'hf:    count = 8'hff;
      default: count = 8'h00;
    endcase
  end
endmodule // div_lookup

// file: verilog/pwm_sample_and_irq_scaler.v
/*
 pwm sample-trigger and interrupt scaler with axi4-lite registers.
 assumes a single 250 mhz clock and a synchronous axi4-lite master.
*/
// Function
// - setting 00 gives one trigger per period
// - 01/10/11 give two, four, eight triggers
// - extra triggers spaced period over factor
// - one base interrupt event per period
// - interrupt every divide count plus one
// - settings 1..15 map through divide table
// - scaled event also starts adc sequence
// - base trigger on slow compare equal count
// - dedicated 14-bit period time base
`timescale 1ns/10ps
module pwm_sample_and_irq_scaler (
  sys_clk,
  rst_n,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  error_adc_trigger,
  general_purpose_adc_start,
  irq
);
`include "pwm_scaler_map.vh"
  input  wire        sys_clk;
  input  wire        rst_n;
  input  wire [7:0]  s_axi_awaddr;
  input  wire        s_axi_awvalid;
  output wire        s_axi_awready;
  input  wire [31:0] s_axi_wdata;
  input  wire [3:0]  s_axi_wstrb;
  input  wire        s_axi_wvalid;
  output wire        s_axi_wready;
  output reg  [1:0]  s_axi_bresp;
  output reg         s_axi_bvalid;
  input  wire        s_axi_bready;
  input  wire [7:0]  s_axi_araddr;
  input  wire        s_axi_arvalid;
  output wire        s_axi_arready;
  output reg  [31:0] s_axi_rdata;
  output reg  [1:0]  s_axi_rresp;
  output reg         s_axi_rvalid;
  input  wire        s_axi_rready;
  output reg         error_adc_trigger;
  output reg         general_purpose_adc_start;
  output wire        irq;

  reg  [31:0]        ctrl_ff;
  reg  [`CNT_W-1:0]  period_ff;
  reg  [11:0]        sample_ff;
  reg  [2:0]         status_ff;
  reg  [2:0]         enable_ff;
  reg  [7:0]         div_cnt_ff;
  reg                aw_ff;
  reg                w_ff;
  reg  [7:0]         awaddr_ff;
  reg  [31:0]        wdata_ff;
  reg  [3:0]         wstrb_ff;
  reg  [2:0]         nxt_status;
  reg  [31:0]        rd_mux;
  reg                rd_ok;
  reg                wr_ok;
  wire [31:0]        wr_merge;
  reg  [`CNT_W-1:0]  sub_off;
  wire [`CNT_W-1:0]  count;
  wire               wrap;
  wire [7:0]         div_limit;
  wire               run;
  wire [1:0]         ovs;
  wire [3:0]         div_set;
  wire               wr_fire;
  wire               base_hit;
  wire               extra_hit;
  wire               scaled;
  wire [`CNT_W-1:0]  base_pos;
  wire [`CNT_W-1:0]  step;
  wire [`CNT_W-1:0]  rel;
  wire [`CNT_W:0]    rel_full;
  integer            k;
  genvar             g;

  assign run     = ctrl_ff[`CTRL_RUN];
  assign ovs     = ctrl_ff[`CTRL_OVS_HI:`CTRL_OVS_LO];
  assign div_set = ctrl_ff[`CTRL_DIV_HI:`CTRL_DIV_LO];

  ////////////////////////////////////////////////////////////////////
  // period counter and divide table
  period_timebase u_timebase (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (run),
    .period  (period_ff),
    .count   (count),
    .wrap    (wrap)
  );

  div_lookup u_div (
    .setting (div_set),
    .count   (div_limit)
  );

  ////////////////////////////////////////////////////////////////////
  // sample trigger compare in slow clock units
  assign base_pos = {sample_ff, {`SLOW_SHIFT{1'b0}}};
  assign base_hit = run & (count == base_pos);

  // step is period length shifted by the factor
  assign step = (ovs == 2'b01) ? ((period_ff + 1'b1) >> 1) :
                (ovs == 2'b10) ? ((period_ff + 1'b1) >> 2) :
                (ovs == 2'b11) ? ((period_ff + 1'b1) >> 3) :
                {`CNT_W{1'b0}};

  // offset from base trigger, wrapped around the period
  assign rel_full = (count >= base_pos) ?
                    {1'b0, count - base_pos} :
                    ({1'b0, count} + {1'b0, period_ff} + 1'b1
                     - {1'b0, base_pos});
  assign rel = rel_full[`CNT_W-1:0];

  // extra hits at base plus k steps
  always @* begin
    sub_off = {`CNT_W{1'b0}};
    for (k = 1; k < 8; k = k + 1) begin
      if ((ovs == 2'b11) || (ovs == 2'b10 && k < 4) ||
          (ovs == 2'b01 && k < 2)) begin
        if (rel == step * k[`CNT_W-1:0])
          sub_off = rel;
      end
    end
  end
  assign extra_hit = run & (ovs != 2'b00) & (step != {`CNT_W{1'b0}}) &
                     (rel != {`CNT_W{1'b0}}) & (sub_off == rel);

  ////////////////////////////////////////////////////////////////////
  // trigger output register
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_adc_trigger <= 1'b0;
    end else begin
      error_adc_trigger <= base_hit | extra_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt divider; restarts on setting write or stop
  assign scaled = wrap & (div_cnt_ff == div_limit);
  assign wr_fire = aw_ff & w_ff & ~s_axi_bvalid;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_ff <= 8'h00;
    end else if (!run ||
                 (wr_fire && awaddr_ff == `OFF_CTRL)) begin
      div_cnt_ff <= 8'h00;
    end else if (wrap) begin
      div_cnt_ff <= scaled ? 8'h00 : div_cnt_ff + 1'b1;
    end
  end

  // adc sequence start follows scaled event
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_purpose_adc_start <= 1'b0;
    end else begin
      general_purpose_adc_start <= scaled;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sticky status; set wins over clear
  always @* begin
    nxt_status = status_ff;
    if (wr_fire && awaddr_ff == `OFF_CLEAR && wstrb_ff[0])
      nxt_status = status_ff & ~wdata_ff[2:0];
    if (error_adc_trigger)
      nxt_status[`ST_SAMPLE] = 1'b1;
    if (wrap)
      nxt_status[`ST_PERIOD] = 1'b1;
    if (scaled)
      nxt_status[`ST_SCALED] = 1'b1;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= 3'b000;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign irq = |(status_ff & enable_ff);

  ////////////////////////////////////////////////////////////////////
  // axi write channel capture
  assign s_axi_awready = ~aw_ff;
  assign s_axi_wready  = ~w_ff;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_ff) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_ff) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_ff <= 1'b0;
      end
    end
  end

  // byte-lane merge onto control register, one lane per pass
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign wr_merge[g*8 +: 8] = wstrb_ff[g] ? wdata_ff[g*8 +: 8] :
                                                ctrl_ff[g*8 +: 8];
    end
  endgenerate

  // decode of mapped offsets; writes to status and count answer okay and change nothing
  always @* begin
    case (awaddr_ff)
      `OFF_CTRL, `OFF_PERIOD, `OFF_SAMPLE,
      `OFF_CLEAR, `OFF_ENABLE, `OFF_STATUS, `OFF_COUNT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // register writes and write response
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff      <= `RST_CTRL;
      period_ff    <= `RST_PERIOD;
      sample_ff    <= `RST_SAMPLE;
      enable_ff    <= 3'b000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        case (awaddr_ff)
          `OFF_CTRL:   ctrl_ff <= {20'h00000, wr_merge[11:8],
                                   2'b00, wr_merge[5:4],
                                   3'b000, wr_merge[0]};
          `OFF_PERIOD: begin
            if (wstrb_ff[0]) period_ff[7:0]  <= wdata_ff[7:0];
            if (wstrb_ff[1]) period_ff[13:8] <= wdata_ff[13:8];
          end
          `OFF_SAMPLE: begin
            if (wstrb_ff[0]) sample_ff[7:0]  <= wdata_ff[7:0];
            if (wstrb_ff[1]) sample_ff[11:8] <= wdata_ff[11:8];
          end
          `OFF_ENABLE: if (wstrb_ff[0]) enable_ff <= wdata_ff[2:0];
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux
  always @* begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `OFF_CTRL:   rd_mux = ctrl_ff;
      `OFF_PERIOD: rd_mux = {18'h00000, period_ff};
      `OFF_SAMPLE: rd_mux = {20'h00000, sample_ff};
      `OFF_STATUS: rd_mux = {29'h0000000, status_ff};
      `OFF_CLEAR:  rd_mux = 32'h0000_0000;
      `OFF_ENABLE: rd_mux = {29'h0000000, enable_ff};
      `OFF_COUNT:  rd_mux = {10'h000, div_cnt_ff, count};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // read data register
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pwm_sample_and_irq_scaler

// file: verif/pwm_scaler_props.sv
/*
 bus and interrupt checks for the pwm sample and interrupt scaler.
 bound to the top module; one clock, async active-low reset.
*/
`timescale 1ns/10ps
module pwm_scaler_props (
  sys_clk,
  rst_n,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  irq
);
  input wire        sys_clk;
  input wire        rst_n;
  input wire        s_axi_awvalid;
  input wire        s_axi_awready;
  input wire        s_axi_wvalid;
  input wire        s_axi_wready;
  input wire [1:0]  s_axi_bresp;
  input wire        s_axi_bvalid;
  input wire        s_axi_bready;
  input wire        s_axi_arvalid;
  input wire        s_axi_arready;
  input wire [31:0] s_axi_rdata;
  input wire [1:0]  s_axi_rresp;
  input wire        s_axi_rvalid;
  input wire        s_axi_rready;
  input wire        irq;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////
  // answers stand until taken, one at a time
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  // both taken at one edge: captured, then answered one edge later
  property p_bans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_bbusy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_bbusy: assert property (p_bbusy) else $error("write taken while busy");
  property p_rbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read answer repeated");

  // interrupt only drops through a register write
  property p_irqfall;
    $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_irqfall: assert property (p_irqfall) else $error("irq drop");
endmodule // pwm_scaler_props

bind pwm_sample_and_irq_scaler pwm_scaler_props u_props (
  .sys_clk(sys_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq)
);

// file: verif/adc_irq_sink.sv
/*
 far-side model: error adc front end and adc sequencer inputs.
 counts trigger pulses and stamps the cycles between pulses.
*/
`timescale 1ns/10ps
module adc_irq_sink (
  sys_clk,
  rst_n,
  error_adc_trigger,
  general_purpose_adc_start,
  trig_cnt_ff,
  trig_gap_ff,
  start_gap_ff
);
  input  wire        sys_clk;
  input  wire        rst_n;
  input  wire        error_adc_trigger;
  input  wire        general_purpose_adc_start;
  output reg  [31:0] trig_cnt_ff;
  output reg  [31:0] trig_gap_ff;
  output reg  [31:0] start_gap_ff;
  reg         [31:0] cyc_ff;
  reg         [31:0] trig_at_ff;
  reg         [31:0] start_at_ff;

  // stamp each pulse and keep the spacing to the one before
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_ff       <= 32'h0;
      trig_cnt_ff  <= 32'h0;
      trig_gap_ff  <= 32'h0;
      start_gap_ff <= 32'h0;
      trig_at_ff   <= 32'h0;
      start_at_ff  <= 32'h0;
    end else begin
      cyc_ff <= cyc_ff + 32'h1;
      if (error_adc_trigger) begin
        trig_cnt_ff <= trig_cnt_ff + 32'h1;
        trig_gap_ff <= cyc_ff - trig_at_ff;
        trig_at_ff  <= cyc_ff;
      end
      if (general_purpose_adc_start) begin
        start_gap_ff <= cyc_ff - start_at_ff;
        start_at_ff  <= cyc_ff;
      end
    end
  end
endmodule // adc_irq_sink

// file: verif/tb_pwm_sample_and_irq_scaler.sv
/*
 testbench for the pwm sample and interrupt scaler.
 bench is the axi4-lite master; the adc side is the sink model.
*/
`timescale 1ns/10ps
`include "pwm_scaler_map.vh"
module tb_pwm_sample_and_irq_scaler;
  reg         sys_clk;
  reg         rst_n;
  reg  [7:0]  s_axi_awaddr;
  reg         s_axi_awvalid;
  wire        s_axi_awready;
  reg  [31:0] s_axi_wdata;
  reg         s_axi_wvalid;
  wire        s_axi_wready;
  wire [1:0]  s_axi_bresp;
  wire        s_axi_bvalid;
  reg         s_axi_bready;
  reg  [7:0]  s_axi_araddr;
  reg         s_axi_arvalid;
  wire        s_axi_arready;
  wire [31:0] s_axi_rdata;
  wire [1:0]  s_axi_rresp;
  wire        s_axi_rvalid;
  reg         s_axi_rready;
  wire        error_adc_trigger;
  wire        general_purpose_adc_start;
  wire        irq;
  wire [31:0] trig_cnt;
  wire [31:0] trig_gap;
  wire [31:0] start_gap;
  reg  [31:0] gap;
  integer     n_mismatch;
  integer     checks;
  integer     i;
  localparam [127:0] DIVS = 128'hffdfbf9f7f5f4f3f2f1f0f0703010000;

  pwm_sample_and_irq_scaler dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .error_adc_trigger(error_adc_trigger), .irq(irq),
    .general_purpose_adc_start(general_purpose_adc_start)
  );
  adc_irq_sink sink (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .error_adc_trigger(error_adc_trigger),
    .general_purpose_adc_start(general_purpose_adc_start),
    .trig_cnt_ff(trig_cnt), .trig_gap_ff(trig_gap), .start_gap_ff(start_gap)
  );

  ////////////////////////////////////////
  // clock, compare and verdict
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input string what, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL %s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  function [31:0] cfg(input r, input [1:0] o, input [3:0] d);
    cfg = {20'h0, d, 2'h0, o, 3'h0, r};
  endfunction

  ////////////////////////////////////////
  // bus tasks: sample at negedge, change after posedge
  // answer ready stays high between transfers; only the watchdog ends a wait
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw, tb;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
        @(negedge sys_clk);
        ta = s_axi_awvalid & s_axi_awready;
        tw = s_axi_wvalid & s_axi_wready;
        tb = s_axi_bvalid & s_axi_bready;
        if (tb)
          chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge sys_clk);
        if (ta)
          s_axi_awvalid <= 1'b0;
        if (tw)
          s_axi_wvalid <= 1'b0;
      end
    end
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    reg ta, tr;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
        @(negedge sys_clk);
        ta = s_axi_arvalid & s_axi_arready;
        tr = s_axi_rvalid & s_axi_rready;
        if (tr) begin
          chk("rdata", ed, s_axi_rdata);
          chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        end
        @(posedge sys_clk);
        if (ta)
          s_axi_arvalid <= 1'b0;
      end
    end
  endtask
  // count triggers over a window after settling
  task span(input integer s, input integer w,
            input [31:0] et, input [31:0] eg);
    reg [31:0] c0;
    begin
      repeat (s) @(posedge sys_clk);
      @(negedge sys_clk);
      c0 = trig_cnt;
      repeat (w) @(negedge sys_clk);
      chk("triggers", et, trig_cnt - c0);
      chk("trig gap", eg, trig_gap);
      @(posedge sys_clk);
    end
  endtask
  task pin(input e);
    begin
      @(negedge sys_clk);
      chk("irq", {31'h0, e}, {31'h0, irq});
      @(posedge sys_clk);
    end
  endtask

  ////////////////////////////////////////
  // watchdog, about twice the expected run
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end

  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 42'h0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 11'h0;
    n_mismatch = 0;
    checks = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`OFF_CTRL, `RST_CTRL, `RESP_OKAY);
    rd(`OFF_PERIOD, {18'h0, `RST_PERIOD}, `RESP_OKAY);
    rd(8'h1c, 32'h0, `RESP_SLVERR);
    wr(8'h1c, 32'h1, `RESP_SLVERR);
    $display("test registers done");
    wr(`OFF_PERIOD, 32'hf, `RESP_OKAY);
    wr(`OFF_SAMPLE, 32'h1, `RESP_OKAY);
    span(0, 64, 32'h0, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`OFF_CTRL, cfg(1'b1, i[1:0], 4'h1), `RESP_OKAY);
      span(40, 160, 32'd10 << i, 32'd16 >> i);
    end
    $display("test oversampling done");
    for (i = 0; i < 16; i = i + 1) begin
      wr(`OFF_CTRL, cfg(1'b1, 2'h0, i[3:0]), `RESP_OKAY);
      gap = ({24'h0, DIVS[8*i +: 8]} + 32'h1) << 4;
      repeat (2 * gap + 40) @(posedge sys_clk);
      pin(1'b0);
      chk("start gap", gap, start_gap);
    end
    $display("test divider done");
    wr(`OFF_CTRL, cfg(1'b1, 2'h0, 4'h1), `RESP_OKAY);
    repeat (40) @(posedge sys_clk);
    wr(`OFF_CTRL, cfg(1'b0, 2'h0, 4'h1), `RESP_OKAY);
    rd(`OFF_STATUS, 32'h7, `RESP_OKAY);
    rd(`OFF_COUNT, 32'h0, `RESP_OKAY);
    wr(`OFF_ENABLE, 32'h4, `RESP_OKAY);
    repeat (20) @(posedge sys_clk);
    pin(1'b1);
    wr(`OFF_ENABLE, 32'h0, `RESP_OKAY);
    pin(1'b0);
    wr(`OFF_ENABLE, 32'h4, `RESP_OKAY);
    wr(`OFF_CLEAR, 32'h4, `RESP_OKAY);
    pin(1'b0);
    rd(`OFF_STATUS, 32'h3, `RESP_OKAY);
    $display("test interrupt done");
    give_verdict;
  end
endmodule // tb_pwm_sample_and_irq_scaler
